// [design/atcrp_pkg.sv]
// Package with register map, field layout and codes of the aux timer capture/reload block
package atcrp_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] CRV_OFS      = 8'h1c;
   localparam logic [7:0] CORE_CTL_OFS = 8'h20;
   localparam logic [7:0] AUX_CTL_OFS  = 8'h24;
   localparam logic [7:0] PORT_SEL_OFS = 8'h28;
   localparam logic [7:0] AUX_TMR_OFS  = 8'h2c;
   localparam logic [7:0] CORE_TMR_OFS = 8'h30;
   // ==========================================================
   // Field positions in the control words
   localparam int EN_BIT   = 15;
   localparam int CLR_BIT  = 14;
   localparam int CE_LSB   = 12;
   localparam int BPS_LSB  = 11;
   localparam int OTL_BIT  = 10;
   localparam int PTS_BIT  = 10;
   localparam int OE_BIT   = 9;
   localparam int RC_BIT   = 9;
   localparam int UD_BIT   = 7;
   localparam int RUN_BIT  = 6;
   localparam int MODE_LSB = 3;
   localparam int INP_LSB  = 0;
   localparam int SRC_BIT  = 0;
   // ==========================================================
   // Reset values
   localparam logic [15:0] TMR_RST    = 16'h0000;
   localparam logic [15:0] CRV_RST    = 16'h0000;
   localparam logic [1:0]  BPS_RST    = 2'h0;
   localparam logic [31:0] RD_RST     = 32'h0000_0000;
   // ==========================================================
   // Block prescaler codes and last count of each division
   localparam logic [1:0] BPS_DIV2  = 2'h1;
   localparam logic [1:0] BPS_DIV4  = 2'h0;
   localparam logic [1:0] BPS_DIV8  = 2'h3;
   localparam logic [3:0] LAST_DIV2 = 4'h1;
   localparam logic [3:0] LAST_DIV4 = 4'h3;
   localparam logic [3:0] LAST_DIV8 = 4'h7;
   localparam logic [3:0] LAST_DIV16 = 4'hf;
   // ==========================================================
   // Timer modes and capture edge codes
   localparam logic [2:0] MODE_TIMER   = 3'h0;
   localparam logic [2:0] MODE_COUNTER = 3'h1;
   localparam logic [2:0] MODE_GATE_LO = 3'h2;
   localparam logic [2:0] MODE_GATE_HI = 3'h3;
   localparam logic [1:0] CE_OFF  = 2'h0;
   localparam logic [1:0] CE_A    = 2'h1;
   localparam logic [1:0] CE_B    = 2'h2;
   localparam logic [1:0] CE_BOTH = 2'h3;
   // ==========================================================
   // Common timer control fields
   typedef struct packed {
      logic       ud;  // Bit 7: count down
      logic       run; // Bit 6: run
      logic [2:0] mode;
      logic [2:0] inp;
   } atcrp_tctl_t;
endpackage

// [design/atcrp_top.sv]
// Aux timer group: core/aux timers, capture/reload register, prescalers, APB slave
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module atcrp_top
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // External pins
   input  wire logic        aux_count_pin,
   input  wire logic        core_count_pin,
   input  wire logic        capture_pin,
   input  wire logic        position_count_input,
   input  wire logic        position_direction_input,
   // Position timer read strobes
   input  wire logic        main_read_pulse,
   input  wire logic        other_read_pulse,
   // Events and pins out
   output logic             toggle_output_pin,
   output logic             core_underflow_pulse,
   output logic             core_timer_irq_line,
   output logic             aux_timer_irq_line,
   output logic             capture_irq_line
);
   // ==========================================================
   // Registers
   logic [15:0]        core_timer;
   logic [15:0]        aux_timer;
   logic [15:0]        capture_reload_value;
   atcrp_pkg::atcrp_tctl_t tctl [2];
   logic               core_reload_enable;
   logic               core_clear_on_capture;
   logic [1:0]         block_prescale_select;
   logic               core_toggle_latch;
   logic               core_output_enable;
   logic               aux_capture_enable;
   logic               aux_clear_on_capture;
   logic [1:0]         capture_edge_select;
   logic               position_trigger_select;
   logic               aux_remote_run;
   logic               read_capture_source_select;
   logic [3:0]         bcnt;
   logic [6:0]         pcnt;
   logic [4:0]         sync1;
   logic [4:0]         sync2;
   logic [4:0]         samp;
   // ==========================================================
   // APB decode
   wire        setup   = psel & ~penable;
   wire        access  = psel & penable & pready;
   wire        wr      = access & pwrite;
   wire        hit_cap = paddr == atcrp_pkg::CRV_OFS;
   wire        hit_cct = paddr == atcrp_pkg::CORE_CTL_OFS;
   wire        hit_act = paddr == atcrp_pkg::AUX_CTL_OFS;
   wire        hit_psl = paddr == atcrp_pkg::PORT_SEL_OFS;
   wire        hit_atm = paddr == atcrp_pkg::AUX_TMR_OFS;
   wire        hit_ctm = paddr == atcrp_pkg::CORE_TMR_OFS;
   wire        mapped  = hit_cap | hit_cct | hit_act | hit_psl | hit_atm | hit_ctm;
   wire        wr_cct  = wr & hit_cct;
   wire        wr_act  = wr & hit_act;
   wire        wr_atm  = wr & hit_atm;
   wire        wr_ctm  = wr & hit_ctm;
   wire [15:0] cct_rd  = {core_reload_enable, core_clear_on_capture, 1'b0,
                          block_prescale_select, core_toggle_latch, core_output_enable,
                          1'b0, tctl[1]};
   wire [15:0] act_rd  = {aux_capture_enable, aux_clear_on_capture, capture_edge_select,
                          1'b0, position_trigger_select, aux_remote_run, 1'b0, tctl[0]};
   wire [15:0] rd_word = hit_cap ? capture_reload_value :
                         hit_cct ? cct_rd :
                         hit_act ? act_rd :
                         hit_psl ? {15'h0000, read_capture_source_select} :
                         hit_atm ? aux_timer :
                         hit_ctm ? core_timer : 16'h0000;

   // Answer in the cycle after setup, read data taken at setup
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= atcrp_pkg::RD_RST;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         if (setup)
         begin
            prdata <= {16'h0000, rd_word};
         end
      end
   end

   // ==========================================================
   // Block prescaler: basic clock tick
   wire [3:0] blast = (block_prescale_select == atcrp_pkg::BPS_DIV2) ? atcrp_pkg::LAST_DIV2 :
                      (block_prescale_select == atcrp_pkg::BPS_DIV4) ? atcrp_pkg::LAST_DIV4 :
                      (block_prescale_select == atcrp_pkg::BPS_DIV8) ? atcrp_pkg::LAST_DIV8 :
                      atcrp_pkg::LAST_DIV16;
   wire       btick = bcnt == blast;

   // Basic clock divider and timer prescaler chain
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bcnt <= 4'h0;
         pcnt <= 7'h00;
      end
      else
      begin
         bcnt <= btick ? 4'h0 : bcnt + 4'h1;
         if (btick)
         begin
            pcnt <= pcnt + 7'h01;
         end
      end
   end

   // ==========================================================
   // Pin synchronisers and basic-clock sampling
   wire [4:0] pins = {position_direction_input, position_count_input, capture_pin,
                      core_count_pin, aux_count_pin};
   wire [4:0] rise;
   wire [4:0] fall;
   genvar k;
   generate
      for (k = 0; k < 5; k++)
      begin : g_pin
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
            begin
               sync1[k] <= 1'b0;
               sync2[k] <= 1'b0;
               samp[k]  <= 1'b0;
            end
            else
            begin
               sync1[k] <= pins[k];
               sync2[k] <= sync1[k];
               if (btick)
               begin
                  samp[k] <= sync2[k];
               end
            end
         end
         // Two consecutive samples differing mark a transition
         assign rise[k] = btick & sync2[k] & ~samp[k];
         assign fall[k] = btick & ~sync2[k] & samp[k];
      end
   endgenerate

   // ==========================================================
   // Per-timer count tick, step and wrap (0 aux, 1 core)
   logic [15:0] tcur [2];
   logic [15:0] step [2];
   logic [1:0]  cnt_tick;
   logic [1:0]  wrap;
   assign tcur[0] = aux_timer;
   assign tcur[1] = core_timer;
   genvar t;
   generate
      for (t = 0; t < 2; t++)
      begin : g_tmr
         wire [6:0] mask   = ~(7'h7f << tctl[t].inp);
         wire       pre    = btick & ((pcnt & mask) == mask);
         wire       run    = (t == 0 && aux_remote_run) ? tctl[1].run : tctl[t].run;
         wire       gate   = (tctl[t].mode == atcrp_pkg::MODE_GATE_LO) ? ~sync2[t] :
                             (tctl[t].mode == atcrp_pkg::MODE_GATE_HI) ? sync2[t] : 1'b1;
         wire       ext    = (tctl[t].inp[0] & rise[t]) | (tctl[t].inp[1] & fall[t]);
         wire       timed  = tctl[t].mode <= atcrp_pkg::MODE_GATE_HI;
         wire       is_cnt = tctl[t].mode == atcrp_pkg::MODE_COUNTER;
         assign cnt_tick[t] = run & (is_cnt ? ext : (timed & gate & pre));
         assign step[t] = tctl[t].ud ? tcur[t] - 16'h0001 : tcur[t] + 16'h0001;
         // Up wraps at all-ones, down wraps at zero
         assign wrap[t] = cnt_tick[t] &
                          (tctl[t].ud ? tcur[t] == 16'h0000 : tcur[t] == 16'hffff);
      end
   endgenerate

   // ==========================================================
   // Capture trigger selection
   wire pos_a   = rise[3] | fall[3];
   wire pos_b   = rise[4] | fall[4];
   wire rd_trig = main_read_pulse | (read_capture_source_select & other_read_pulse);
   wire pos_trig = (capture_edge_select == atcrp_pkg::CE_A) ? pos_a :
                   (capture_edge_select == atcrp_pkg::CE_B) ? pos_b :
                   (capture_edge_select == atcrp_pkg::CE_BOTH) ? (pos_a | pos_b) : 1'b0;
   wire pin_trig = (capture_edge_select == atcrp_pkg::CE_A) ? (rise[2] | rd_trig) :
                   (capture_edge_select == atcrp_pkg::CE_B) ? fall[2] :
                   (capture_edge_select == atcrp_pkg::CE_BOTH) ? (rise[2] | fall[2]) : 1'b0;
   wire cap_trig = position_trigger_select ? pos_trig : pin_trig;
   wire do_cap   = cap_trig & aux_capture_enable;
   wire clr_aux  = cap_trig & aux_clear_on_capture;
   wire clr_core = cap_trig & core_clear_on_capture;
   wire reload   = wrap[1] & core_reload_enable;

   // ==========================================================
   // Control registers
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tctl[0]                    <= '0;
         tctl[1]                    <= '0;
         core_reload_enable         <= 1'b0;
         core_clear_on_capture      <= 1'b0;
         block_prescale_select      <= atcrp_pkg::BPS_RST;
         core_output_enable         <= 1'b0;
         aux_capture_enable         <= 1'b0;
         aux_clear_on_capture       <= 1'b0;
         capture_edge_select        <= atcrp_pkg::CE_OFF;
         position_trigger_select    <= 1'b0;
         aux_remote_run             <= 1'b0;
         read_capture_source_select <= 1'b0;
      end
      else
      begin
         if (wr_cct)
         begin
            tctl[1]               <= pwdata[7:0];
            core_reload_enable    <= pwdata[atcrp_pkg::EN_BIT];
            core_clear_on_capture <= pwdata[atcrp_pkg::CLR_BIT];
            block_prescale_select <= pwdata[atcrp_pkg::BPS_LSB +: 2];
            core_output_enable    <= pwdata[atcrp_pkg::OE_BIT];
         end
         if (wr_act)
         begin
            tctl[0]                 <= pwdata[7:0];
            aux_capture_enable      <= pwdata[atcrp_pkg::EN_BIT];
            aux_clear_on_capture    <= pwdata[atcrp_pkg::CLR_BIT];
            capture_edge_select     <= pwdata[atcrp_pkg::CE_LSB +: 2];
            position_trigger_select <= pwdata[atcrp_pkg::PTS_BIT];
            aux_remote_run          <= pwdata[atcrp_pkg::RC_BIT];
         end
         if (wr & hit_psl)
         begin
            read_capture_source_select <= pwdata[atcrp_pkg::SRC_BIT];
         end
      end
   end

   // ==========================================================
   // Timers, capture/reload register and toggle latch
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aux_timer            <= atcrp_pkg::TMR_RST;
         core_timer           <= atcrp_pkg::TMR_RST;
         capture_reload_value <= atcrp_pkg::CRV_RST;
         core_toggle_latch    <= 1'b0;
      end
      else
      begin
         if (wr_atm)
            aux_timer <= pwdata[15:0];
         else if (clr_aux)
            aux_timer <= 16'h0000;
         else if (cnt_tick[0])
            aux_timer <= step[0];
         if (wr_ctm)
            core_timer <= pwdata[15:0];
         else if (clr_core)
            core_timer <= 16'h0000;
         else if (reload)
            core_timer <= capture_reload_value;
         else if (cnt_tick[1])
            core_timer <= step[1];
         // Capture wins over a software write in the same cycle
         if (do_cap)
            capture_reload_value <= aux_timer;
         else if (wr & hit_cap)
            capture_reload_value <= pwdata[15:0];
         if (wrap[1])
            core_toggle_latch <= ~core_toggle_latch;
         else if (wr_cct)
            core_toggle_latch <= pwdata[atcrp_pkg::OTL_BIT];
      end
   end

   // Registered event pulses and toggle pin
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         core_underflow_pulse <= 1'b0;
         core_timer_irq_line  <= 1'b0;
         aux_timer_irq_line   <= 1'b0;
         capture_irq_line     <= 1'b0;
         toggle_output_pin    <= 1'b0;
      end
      else
      begin
         core_underflow_pulse <= wrap[1];
         core_timer_irq_line  <= wrap[1];
         aux_timer_irq_line   <= wrap[0];
         capture_irq_line     <= cap_trig;
         toggle_output_pin    <= core_toggle_latch & core_output_enable;
      end
   end

   // ==========================================================
   // Checks
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_reload_load: assert property (
      reload && !wr_ctm && !clr_core |=> core_timer == $past(capture_reload_value))
      else $error("core timer not reloaded on wrap");
   a_reload_no_capirq: assert property (
      wrap[1] && !cap_trig |=> core_timer_irq_line && !capture_irq_line)
      else $error("reload irq lines wrong");
   a_wrap_toggle: assert property (
      wrap[1] |=> core_toggle_latch != $past(core_toggle_latch) && core_underflow_pulse)
      else $error("toggle latch or pulse missing");
   a_capture_value: assert property (
      do_cap |=> capture_reload_value == $past(aux_timer) && capture_irq_line)
      else $error("capture value wrong");
   a_aux_clear: assert property (
      clr_aux && !wr_atm |=> aux_timer == 16'h0000)
      else $error("aux timer not cleared");
   a_core_under: assert property (
      cnt_tick[1] && tctl[1].ud && core_timer == 16'h0000 && !core_reload_enable
      && !clr_core && !wr_ctm |=> core_timer == 16'hffff)
      else $error("underflow value wrong");
   a_div4_period: assert property (
      disable iff (!rst_n || wr_cct)
      btick && block_prescale_select == atcrp_pkg::BPS_DIV4 |=> !btick [*3] ##1 btick)
      else $error("divide by four period wrong");
   a_fall_capture: assert property (
      !position_trigger_select && capture_edge_select == atcrp_pkg::CE_B && fall[2]
      && aux_capture_enable |=> capture_reload_value == $past(aux_timer))
      else $error("falling edge capture missing");
endmodule
`default_nettype wire

// [dv/atcrp_sensor_model.sv]
// Model of the external trigger, sensor and count sources of the timer block
`timescale 1ns/1ps
`default_nettype none
module atcrp_sensor_model
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Requests from the bench
   input  wire logic [4:0] toggle_req,
   input  wire logic [4:0] hold_cycles,
   output logic            busy,
   // Pins toward the block
   output logic [4:0]      pins
);
   logic [5:0] hold_cnt;
   // ==========================================================
   // Toggle requested pins, then keep every level for the hold span
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pins     <= 5'h00;
         hold_cnt <= 6'h00;
      end
      else if (hold_cnt != 6'h00)
      begin
         hold_cnt <= hold_cnt - 6'h01;
      end
      else if (toggle_req != 5'h00)
      begin
         pins     <= pins ^ toggle_req;
         hold_cnt <= {hold_cycles, 1'b0};
      end
   end
   // Busy while a request waits or a level is still held
   assign busy = (hold_cnt != 6'h00) || (toggle_req != 5'h00);
endmodule
`default_nettype wire

// [dv/test_aux_timer_capture_reload_prescaler.sv]
// Self-checking bench for the aux timer capture/reload block
`timescale 1ns/1ps
`default_nettype none
module test_aux_timer_capture_reload_prescaler;
   // ==========================================================
   // Signals
   logic        clock, rst_n, psel, penable, pwrite, main_rd, other_rd;
   logic        pready, pslverr, tog, ouf, irq_core, irq_aux, irq_cap, busy, err, t0;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, seed, d, cyc, nv;
   logic [4:0]  pins, req;
   logic [1:0]  esel;
   logic        pos_sel, rise, trig;
   int          num_errors = 0;
   int          n_compared = 0;
   int          n_cap = 0;
   int          n_aux = 0;
   int          n_core = 0;
   int          r, inp, c0, c1;
   // ==========================================================
   // Design and partner
   atcrp_top DUT
   (
      .clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .aux_count_pin(pins[3]), .core_count_pin(pins[4]), .capture_pin(pins[0]),
      .position_count_input(pins[1]), .position_direction_input(pins[2]),
      .main_read_pulse(main_rd), .other_read_pulse(other_rd), .toggle_output_pin(tog),
      .core_underflow_pulse(ouf), .core_timer_irq_line(irq_core),
      .aux_timer_irq_line(irq_aux), .capture_irq_line(irq_cap)
   );
   atcrp_sensor_model partner
   (
      .clock, .rst_n, .toggle_req(req), .hold_cycles(5'h10), .busy, .pins
   );
   // ==========================================================
   // Clock and event counters
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock)
   begin
      if (irq_cap === 1'b1) n_cap++;
      if (irq_aux === 1'b1) n_aux++;
      if (irq_core === 1'b1) n_core++;
   end
   // ==========================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] fld(input int v, input int p);
      return 32'(v) << p;
   endfunction
   function automatic int fac(input logic [1:0] b);
      case (b)
         2'h1: return 2;
         2'h0: return 4;
         2'h3: return 8;
         default: return 16;
      endcase
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // APB transfer; read data and error land in d and err
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clock);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20) num_errors++;
      d = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(d, exp);
      check(32'(err), 32'h0);
   endtask
   // Pin toggles (bits 4:0) and read strobes (bits 5, 6), then settle
   task automatic fire(input logic [6:0] m);
      int n;
      n = 0;
      @(posedge clock);
      req      <= m[4:0];
      main_rd  <= m[5];
      other_rd <= m[6];
      @(posedge clock);
      req      <= 5'h00;
      main_rd  <= 1'b0;
      other_rd <= 1'b0;
      @(negedge clock);
      while (busy === 1'b1 && n < 100)
      begin
         @(negedge clock);
         n++;
      end
      repeat (8) @(negedge clock);
   endtask
   // Cycles between two core wraps, events watched meanwhile
   task automatic measure();
      int n;
      n = 0;
      @(negedge clock);
      while (ouf !== 1'b1 && n < 4000)
      begin
         @(negedge clock);
         n++;
      end
      t0 = tog;
      cyc = 0;
      do
      begin
         @(negedge clock);
         cyc++;
         check(32'({irq_core, irq_cap}), 32'({ouf, 1'b0}));
      end
      while (ouf !== 1'b1 && cyc < 4000);
   endtask
   task automatic end_sim;
      if (num_errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ==========================================================
   // Watchdog
   initial
   begin
      #2000000;
      num_errors++;
      end_sim;
   end
   // ==========================================================
   // Main sequence
   initial
   begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, req, main_rd, other_rd} = '0;
      seed = 32'hd178;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      // Reset values, then an unmapped place
      for (int a = 0; a < 6; a++)
      begin
         rdc(atcrp_pkg::CRV_OFS + 8'(4 * a), 32'h0);
      end
      wr(8'h34, 32'h1234);
      check(32'(err), 32'h1);
      // Reload period over all prescaler codes, both directions
      for (int i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         r = int'(seed[4:0]) % 24;
         inp = int'(seed[9:8]) % 3;
         nv = (i > 3) ? 32'(r) : 32'hffff - 32'(r);
         wr(atcrp_pkg::CORE_CTL_OFS, fld(i % 4, atcrp_pkg::BPS_LSB));
         wr(atcrp_pkg::CRV_OFS, nv);
         wr(atcrp_pkg::CORE_TMR_OFS, nv);
         // Reload, output enable and run on top of the chosen fields
         wr(atcrp_pkg::CORE_CTL_OFS, fld(i % 4, atcrp_pkg::BPS_LSB) | fld(i / 4, atcrp_pkg::UD_BIT)
            | fld(inp, atcrp_pkg::INP_LSB) | 32'h0000_8240);
         measure();
         check(cyc, 32'((r + 1) * fac(2'(i)) << inp));
         check(32'(tog), {31'h0, ~t0});
         wr(atcrp_pkg::CORE_CTL_OFS, 32'h0);
      end
      // Capture sources and edges; reload armed, core stopped but cleared on capture, div 2
      wr(atcrp_pkg::CORE_CTL_OFS, 32'h0000_c800);
      for (int i = 0; i < 20; i++)
      begin
         seed = lfsr(seed);
         pos_sel = (i < 16) && i[3];
         esel = (i < 16) ? 2'(i >> 1) : 2'h1;
         rise = !pins[0];
         if (i >= 16) trig = !i[0] || i[1];
         else if (pos_sel) trig = i[0] ? esel[1] : esel[0];
         else trig = (esel == 2'h3) || (esel == 2'h1 && rise) || (esel == 2'h2 && !rise);
         wr(atcrp_pkg::PORT_SEL_OFS, 32'(i[1]));
         wr(atcrp_pkg::AUX_CTL_OFS, 32'h0000_c000 | fld(esel, atcrp_pkg::CE_LSB)
            | fld(pos_sel, atcrp_pkg::PTS_BIT));
         wr(atcrp_pkg::AUX_TMR_OFS, {16'h0, seed[15:0]});
         wr(atcrp_pkg::CRV_OFS, {16'h0, ~seed[15:0]});
         wr(atcrp_pkg::CORE_TMR_OFS, {16'h0, seed[31:16]});
         c0 = n_cap;
         fire(i >= 16 ? (i[0] ? 7'h40 : 7'h20) : (pos_sel ? (i[0] ? 7'h04 : 7'h02) : 7'h01));
         check(32'(n_cap - c0), 32'(trig));
         rdc(atcrp_pkg::CRV_OFS, {16'h0, trig ? seed[15:0] : ~seed[15:0]});
         rdc(atcrp_pkg::AUX_TMR_OFS, {16'h0, trig ? 16'h0 : seed[15:0]});
         rdc(atcrp_pkg::CORE_TMR_OFS, {16'h0, trig ? 16'h0 : seed[31:16]});
      end
      // Counter mode: aux down from zero, core up from all-ones
      wr(atcrp_pkg::AUX_TMR_OFS, 32'h0);
      wr(atcrp_pkg::CORE_TMR_OFS, 32'hffff);
      wr(atcrp_pkg::CRV_OFS, {16'h0, seed[15:0]});
      wr(atcrp_pkg::AUX_CTL_OFS, 32'h0000_00c9);
      wr(atcrp_pkg::CORE_CTL_OFS, 32'h0000_8849);
      c0 = n_aux;
      c1 = n_core;
      fire(7'h18);
      check(32'(n_aux - c0), 32'h1);
      check(32'(n_core - c1), 32'h1);
      rdc(atcrp_pkg::AUX_TMR_OFS, 32'hffff);
      rdc(atcrp_pkg::CORE_TMR_OFS, {16'h0, seed[15:0]});
      fire(7'h18);
      rdc(atcrp_pkg::AUX_TMR_OFS, 32'hffff);
      // Gated aux run from the core run bit; core counts down without reload
      wr(atcrp_pkg::CORE_TMR_OFS, 32'h0);
      wr(atcrp_pkg::CORE_CTL_OFS, 32'h0000_08c0);
      for (int g = 0; g < 2; g++)
      begin
         // Gate pin is low: gate-low mode counts, gate-high mode holds
         wr(atcrp_pkg::AUX_CTL_OFS, 32'h0000_0210 | fld(g, atcrp_pkg::MODE_LSB));
         wr(atcrp_pkg::AUX_TMR_OFS, 32'h0);
         repeat (40) @(posedge clock);
         apb(1'b0, atcrp_pkg::AUX_TMR_OFS, 32'h0);
         check(32'(d != 32'h0), 32'(g == 0));
      end
      end_sim;
   end
endmodule
`default_nettype wire
